/* shared/supervisor_map.svh */
// Constants of the quad supervisor: the clock rate and the timing figures.
// Assumes it is included by its bare name.
`ifndef SUPERVISOR_MAP_SVH
`define SUPERVISOR_MAP_SVH

// ********************************************************************
// Clock and timing figures
// ********************************************************************
`define SUP_CLK_KHZ        40000
`define SUP_FIXED_DELAY_US 21000
`define SUP_MIN_DELAY_US   1450
`define SUP_MAX_DELAY_US   10000000
`define SUP_WDT_US         630000

// Least times round up, longest times round down, in 64-bit arithmetic.
`define SUP_CYC_UP(us)   ((64'(us) * 64'(`SUP_CLK_KHZ) + 64'd999) / 64'd1000)
`define SUP_CYC_DOWN(us) ((64'(us) * 64'(`SUP_CLK_KHZ)) / 64'd1000)

// ********************************************************************
// Reset values
// ********************************************************************
`define SUP_RST_RELEASED 1'b0
`define SUP_RST_WDT_FLT  1'b0

`endif

/* shared/supervisor_pkg.sv */
// Types shared by the quad supervisor modules.
// Assumes nothing of its surroundings.
package supervisor_pkg;

	// Release timer states.
	typedef enum logic [1:0] {
		ST_HOLD     = 2'b00,
		ST_COUNT    = 2'b01,
		ST_RELEASED = 2'b10
	} rel_state_e;

	// Channel numbering of the four supervisor channels.
	typedef enum logic [1:0] {
		CH_ONE   = 2'b00,
		CH_TWO   = 2'b01,
		CH_THREE = 2'b10,
		CH_FOUR  = 2'b11
	} chan_id_e;

endpackage

/* shared/release_if.sv */
// Link between the supervisor core and one channel's release timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface release_if #(
	parameter int CNT_W = 29
);
	logic             fault;
	logic [CNT_W-1:0] delay;
	logic             released;

	modport timer (input fault, input delay, output released);
	modport ctrl  (output fault, output delay, input released);
endinterface

`default_nettype wire

/* rtl/release_timer.sv */
// Per-channel release timer: asserts at once on a fault, releases after a delay.
// Assumes a synchronised fault level and a delay count held stable by the core.
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_map.svh"

module release_timer #(
	parameter int CNT_W = 29
) (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	release_if.timer  link
);

	supervisor_pkg::rel_state_e state_r;
	supervisor_pkg::rel_state_e state_nxt;
	logic [CNT_W-1:0]           cnt_r;
	logic [CNT_W-1:0]           cnt_nxt;
	logic                       released_r;
	wire logic                  done;

	// The count ends one cycle before the delay so that the release lands on it.
	assign done = (cnt_r >= link.delay - CNT_W'(1));

	// ****************************************************************
	// Next state
	// ****************************************************************
	// A fault wins in every state and clears the count.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		if (link.fault) begin
			state_nxt = supervisor_pkg::ST_HOLD; // R13
			cnt_nxt   = '0;
		end else begin
			unique case (state_r)
				supervisor_pkg::ST_HOLD: begin
					state_nxt = supervisor_pkg::ST_COUNT; // R5
					cnt_nxt   = '0;
				end
				supervisor_pkg::ST_COUNT: begin
					if (done) begin
						state_nxt = supervisor_pkg::ST_RELEASED; // R5
					end else begin
						cnt_nxt = cnt_r + CNT_W'(1);
					end
				end
				supervisor_pkg::ST_RELEASED: begin
					state_nxt = supervisor_pkg::ST_RELEASED;
				end
				default: begin
					state_nxt = supervisor_pkg::ST_HOLD;
				end
			endcase
		end
	end

	// State, count and the registered release level; reset starts the delay.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r    <= supervisor_pkg::ST_COUNT; // R16
			cnt_r      <= '0;
			released_r <= `SUP_RST_RELEASED;
		end else begin
			state_r    <= state_nxt;
			cnt_r      <= cnt_nxt;
			released_r <= (state_nxt == supervisor_pkg::ST_RELEASED);
		end
	end

	assign link.released = released_r;

endmodule

`default_nettype wire

/* rtl/quad_supervisor_reset_watchdog.sv */
// Digital core of a four-channel supply supervisor with manual reset and watchdog.
// Assumes comparator flags, manual reset and kick arrive as logic levels on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_map.svh"

// How it works
// R1 - A low manual reset input forces channel 1 reset low whatever its rail says.
// R2 - Channels 1 to 3 hold their reset low while their rail is below its falling threshold.
// R3 - Channel 4 holds its reset low while the lower window rail is below its threshold.
// R4 - Channel 4 also holds its reset low while the upper window rail is above its threshold.
// R5 - When a channel's fault clears, its reset stays low for the delay and then goes high.
// R6 - Each channel has its own delay, kept between 1.45 ms and 10 s.
// R7 - The delay select picks the fixed delay when high and the programmed delay when low.
// R8 - The watchdog fault output goes low on a watchdog timeout and is high otherwise.
// R9 - Every edge of the kick input restarts the watchdog period of 630 ms.
// R10 - Channel 1 release starts a fresh period, and no timeout counts while it is asserted.
// R11 - A build option makes the outputs open-drain or push-pull.
// R12 - A watchdog fault stays latched until channel 1 reset is asserted again.
// R13 - A new fault asserts a channel reset at once, with no delay.
// R14 - Channel 1 releases only once manual reset is high and its rail is good.
// R15 - The rail, window, manual reset and kick inputs are synchronised and the periods are cycle counters with parameter ends.
// R16 - Power-on reset asserts every reset, clears the watchdog fault and starts the delays.
module quad_supervisor_reset_watchdog #(
	parameter int          CNT_W         = 29,
	parameter bit          OPEN_DRAIN    = 1'b1,
	parameter logic [28:0] FIXED_CYCLES  = 29'(`SUP_CYC_DOWN(`SUP_FIXED_DELAY_US)),
	parameter logic [28:0] MIN_CYCLES    = 29'(`SUP_CYC_UP(`SUP_MIN_DELAY_US)),
	parameter logic [28:0] MAX_CYCLES    = 29'(`SUP_CYC_DOWN(`SUP_MAX_DELAY_US)),
	parameter logic [28:0] WDT_CYCLES    = 29'(`SUP_CYC_DOWN(`SUP_WDT_US))
) (
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	input  wire logic [2:0]            rail_sense,
	input  wire logic                  lower_window_sense,
	input  wire logic                  upper_window_sense,
	input  wire logic                  manual_reset_n,
	input  wire logic                  watchdog_kick,
	input  wire logic [3:0]            delay_config,
	input  wire logic [3:0][CNT_W-1:0] delay_prog_cycles,
	output logic      [3:0]            channel_reset_out_n,
	output logic      [3:0]            channel_reset_oe,
	output logic                       watchdog_fault_n,
	output logic                       watchdog_fault_oe
);

	localparam int NSYNC = 7;

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	wire logic [NSYNC-1:0] raw_in;
	logic      [NSYNC-1:0] meta_r;
	logic      [NSYNC-1:0] sync_r;
	logic                  kick_prev_r;

	// Bit order of the bank: rails, lower window, upper window, manual reset, kick.
	assign raw_in = {watchdog_kick, manual_reset_n, upper_window_sense,
	                 lower_window_sense, rail_sense};

	// Two flip-flops per input; only the second stage feeds the logic.
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					meta_r[gi] <= 1'b0;
					sync_r[gi] <= 1'b0;
				end else begin
					meta_r[gi] <= raw_in[gi]; // R15
					sync_r[gi] <= meta_r[gi];
				end
			end
		end
	endgenerate

	wire logic [2:0] rail_ok_s;
	wire logic       lower_ok_s;
	wire logic       upper_over_s;
	wire logic       mr_n_s;
	wire logic       kick_s;

	assign rail_ok_s    = sync_r[2:0];
	assign lower_ok_s   = sync_r[3];
	assign upper_over_s = sync_r[4];
	assign mr_n_s       = sync_r[5];
	assign kick_s       = sync_r[6];

	// ****************************************************************
	// Kick history
	// ****************************************************************
	// Holds the last synchronised kick level for the edge detector.
	// It resets to the kick's idle low, so no false edge follows reset.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			kick_prev_r <= 1'b0;
		end else begin
			kick_prev_r <= kick_s;
		end
	end

	// ****************************************************************
	// Fault decode per channel
	// ****************************************************************
	wire logic       mr_fault;
	wire logic [2:0] rail_fault;
	wire logic       lower_fault;
	wire logic       upper_fault;
	wire logic [3:0] fault;

	// Each source brought to a common high-means-fault sense.
	assign mr_fault    = ~mr_n_s; // R1
	assign rail_fault  = ~rail_ok_s; // R2
	assign lower_fault = ~lower_ok_s; // R3
	assign upper_fault = upper_over_s; // R4

	// Channel 1 needs both manual reset high and a good rail to release.
	assign fault[0] = mr_fault | rail_fault[0]; // R1 R2 R14
	assign fault[1] = rail_fault[1]; // R2
	assign fault[2] = rail_fault[2]; // R2
	assign fault[3] = lower_fault | upper_fault; // R3 R4

	// ****************************************************************
	// Release timers
	// ****************************************************************
	wire logic [3:0] released;

	// Each channel picks and clamps its own delay, then runs its own timer.
	generate
		for (gi = 0; gi < 4; gi++) begin : g_chan
			wire logic [CNT_W-1:0] prog_clamped;
			wire logic [CNT_W-1:0] delay_sel;

			release_if #(.CNT_W(CNT_W)) u_link ();

			assign prog_clamped =
				(delay_prog_cycles[gi] < CNT_W'(MIN_CYCLES)) ? CNT_W'(MIN_CYCLES) :
				(delay_prog_cycles[gi] > CNT_W'(MAX_CYCLES)) ? CNT_W'(MAX_CYCLES) :
				delay_prog_cycles[gi]; // R6
			assign delay_sel = delay_config[gi] ? CNT_W'(FIXED_CYCLES) : prog_clamped; // R7
			assign u_link.fault = fault[gi];
			assign u_link.delay = delay_sel;
			assign released[gi] = u_link.released;

			release_timer #(
				.CNT_W (CNT_W)
			) u_timer (
				.ref_clk (ref_clk),
				.sys_rst (sys_rst),
				.link    (u_link.timer)
			);
		end
	endgenerate

	// ****************************************************************
	// Watchdog
	// ****************************************************************
	logic [CNT_W-1:0] wdt_cnt_r;
	logic [CNT_W-1:0] wdt_cnt_nxt;
	logic             wdt_flt_r;
	logic             wdt_flt_nxt;
	wire logic        kick_edge;
	wire logic        wdt_expire;
	wire logic        wdt_hold;
	wire logic        wdt_frozen;
	wire logic        wdt_restart;
	wire logic        wdt_timeout;

	// Either edge of the synchronised kick counts as a restart.
	assign kick_edge  = kick_s ^ kick_prev_r; // R9
	assign wdt_expire = (wdt_cnt_r >= CNT_W'(WDT_CYCLES) - CNT_W'(1));

	// Event priority: channel 1 reset, then a latched fault, then a kick, then the timeout.
	assign wdt_hold    = ~released[0]; // R10
	assign wdt_frozen  = ~wdt_hold & wdt_flt_r; // R12
	assign wdt_restart = ~wdt_hold & ~wdt_flt_r & kick_edge; // R9
	assign wdt_timeout = ~wdt_hold & ~wdt_flt_r & ~kick_edge & wdt_expire; // R8

	// Held at zero while channel 1 is asserted, so release starts a fresh period.
	always_comb begin
		wdt_cnt_nxt = wdt_cnt_r;
		wdt_flt_nxt = wdt_flt_r;
		if (wdt_hold) begin
			wdt_cnt_nxt = '0; // R10
			wdt_flt_nxt = 1'b0; // R12
		end else if (wdt_frozen) begin
			wdt_cnt_nxt = wdt_cnt_r; // R12
		end else if (wdt_restart) begin
			wdt_cnt_nxt = '0; // R9
		end else if (wdt_timeout) begin
			wdt_flt_nxt = 1'b1; // R8
		end else begin
			wdt_cnt_nxt = wdt_cnt_r + CNT_W'(1); // R15
		end
	end

	// Watchdog count and latched fault.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wdt_cnt_r   <= '0;
			wdt_flt_r   <= `SUP_RST_WDT_FLT; // R16
		end else begin
			wdt_cnt_r   <= wdt_cnt_nxt;
			wdt_flt_r   <= wdt_flt_nxt;
		end
	end

	// ****************************************************************
	// Output stage
	// ****************************************************************
	// Open-drain drives only the low level; push-pull drives both levels.
	// A released open-drain line relies on the board pull-up for its high level.
	assign channel_reset_out_n = released; // R5
	assign channel_reset_oe    = OPEN_DRAIN ? ~released : 4'hF; // R11

	// The fault pin follows the latched flag, low while it is set.
	assign watchdog_fault_n    = ~wdt_flt_r; // R8
	assign watchdog_fault_oe   = OPEN_DRAIN ? wdt_flt_r : 1'b1; // R11

endmodule

`default_nettype wire

/* tb/sup_monitor.sv */
// Assertion checker watching the quad supervisor top module ports.
// Assumes a bind from the bench top file; one clock, reset active high.
`timescale 1ns/1ps
`default_nettype none
// ********************************************************************
// Checker
// ********************************************************************
module sup_monitor #(
	parameter int FIXED_CYCLES = 20,
	parameter int WDT_CYCLES   = 50
) (
	input wire logic       ref_clk,
	input wire logic       sys_rst,
	input wire logic [2:0] rail_sense,
	input wire logic       upper_window_sense,
	input wire logic       manual_reset_n,
	input wire logic       watchdog_kick,
	input wire logic [3:0] delay_config,
	input wire logic [3:0] channel_reset_out_n,
	input wire logic       watchdog_fault_n
);
	logic [15:0] good_r;
	logic [15:0] wd_r;
	logic        kick_r;
	wire logic   wd_clr = !channel_reset_out_n[0] || (watchdog_kick != kick_r);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// Counts good cycles of the channel 3 rail and quiet cycles of the watchdog.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			good_r <= 16'h0000;
			wd_r   <= 16'h0000;
			kick_r <= 1'b0;
		end else begin
			good_r <= rail_sense[2] ? good_r + 16'h0001 : 16'h0000;
			wd_r   <= wd_clr ? 16'h0000 : wd_r + 16'h0001;
			kick_r <= watchdog_kick;
		end
	end
	property p_mr; $fell(manual_reset_n) |-> ##[1:4] !channel_reset_out_n[0]; endproperty
	a_mr: assert property (p_mr) else $error("ch1 missed manual reset");
	property p_rail; $fell(rail_sense[1]) |-> ##[1:4] !channel_reset_out_n[1]; endproperty
	a_rail: assert property (p_rail) else $error("ch2 missed rail fault");
	property p_up; $rose(upper_window_sense) |-> ##[1:4] !channel_reset_out_n[3]; endproperty
	a_up: assert property (p_up) else $error("ch4 missed upper fault");
	property p_rel; $rose(channel_reset_out_n[2]) && delay_config[2] |->
		good_r >= 16'(FIXED_CYCLES + 1) && good_r <= 16'(FIXED_CYCLES + 5); endproperty
	a_rel: assert property (p_rel) else $error("ch3 release delay off");
	property p_wdt; $fell(watchdog_fault_n) |->
		wd_r >= 16'(WDT_CYCLES - 1) && wd_r <= 16'(WDT_CYCLES + 6); endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog period off");
	property p_hold; !channel_reset_out_n[0] [*3] |-> watchdog_fault_n; endproperty
	a_hold: assert property (p_hold) else $error("fault during ch1 reset");
	property p_latch; !watchdog_fault_n && channel_reset_out_n[0] |=> !watchdog_fault_n;
	endproperty
	a_latch: assert property (p_latch) else $error("fault not latched");
	property p_por; $fell(sys_rst) |-> channel_reset_out_n == 4'h0 && watchdog_fault_n;
	endproperty
	a_por: assert property (p_por) else $error("bad state after reset");
endmodule
`default_nettype wire

/* tb/host_model.sv */
// Processor model: held in reset by channel 1, it kicks the watchdog.
// Assumes its reset input is the resolved channel 1 pin.
`timescale 1ns/1ps
`default_nettype none
// ********************************************************************
// Processor
// ********************************************************************
module host_model #(
	parameter int GAP = 20
) (
	input  wire logic ref_clk,
	input  wire logic cpu_rst_n,
	input  wire logic kick_en,
	output var logic  watchdog_kick
);
	int cnt_r;
	initial watchdog_kick = 1'b0;
	// Toggles the kick well inside the watchdog period while running.
	always @(posedge ref_clk) begin
		cnt_r <= (cnt_r >= GAP) ? 0 : cnt_r + 1;
		if (cpu_rst_n && kick_en && cnt_r == GAP)
			watchdog_kick <= #2 ~watchdog_kick;
	end
endmodule
`default_nettype wire

/* tb/test_quad_supervisor_reset_watchdog.sv */
// Self-checking bench for the quad supervisor with a processor model.
// Assumes design, package, interface, checker and model compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
// ********************************************************************
// Bench
// ********************************************************************
module test_quad_supervisor_reset_watchdog;
	localparam int FIX = 20;
	localparam int PRG = 6;
	localparam int WDT = 50;
	localparam int MINC = 4;
	localparam int MAXC = 1000;
	logic            ref_clk, sys_rst, manual_reset_n, kick_en;
	logic            lower_window_sense, upper_window_sense;
	logic [2:0]      rail_sense;
	logic [3:0]      delay_config;
	logic [3:0][28:0] delay_prog_cycles;
	wire logic [3:0] pp_rst_n, pp_rst_oe;
	wire logic       pp_wdo_n, pp_wdo_oe;
	wire logic       watchdog_kick, watchdog_fault_n, watchdog_fault_oe, wdo_pin;
	wire logic [3:0] channel_reset_out_n, channel_reset_oe, rst_pin;
	int              miscompares = 0;
	int              n_compared = 0;
	// Board pins, pulled up wherever a line is released.
	assign rst_pin = ~channel_reset_oe | channel_reset_out_n;
	assign wdo_pin = ~watchdog_fault_oe | watchdog_fault_n;
	quad_supervisor_reset_watchdog #(.FIXED_CYCLES(29'h14), .MIN_CYCLES(29'h4),
		.MAX_CYCLES(29'h3E8), .WDT_CYCLES(29'h32)) quad_supervisor_reset_watchdog_inst (
		.ref_clk, .sys_rst, .rail_sense, .lower_window_sense, .upper_window_sense,
		.manual_reset_n, .watchdog_kick, .delay_config, .delay_prog_cycles,
		.channel_reset_out_n, .channel_reset_oe,
		.watchdog_fault_n, .watchdog_fault_oe);
	host_model host_model_inst (.ref_clk, .cpu_rst_n(rst_pin[0]), .kick_en, .watchdog_kick);
	// Push-pull build on the same inputs; its lines are read directly.
	quad_supervisor_reset_watchdog #(.OPEN_DRAIN(1'b0), .FIXED_CYCLES(29'h14),
		.MIN_CYCLES(29'h4), .MAX_CYCLES(29'h3E8), .WDT_CYCLES(29'h32)) push_pull_inst (
		.ref_clk, .sys_rst, .rail_sense, .lower_window_sense, .upper_window_sense,
		.manual_reset_n, .watchdog_kick, .delay_config, .delay_prog_cycles,
		.channel_reset_out_n(pp_rst_n), .channel_reset_oe(pp_rst_oe),
		.watchdog_fault_n(pp_wdo_n), .watchdog_fault_oe(pp_wdo_oe));
	// Clock at 40 MHz.
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask
	// Puts one fault source into or out of its fault level.
	task automatic set_flt(input int k, input logic bad);
		case (k)
			0: manual_reset_n = !bad;
			1, 2, 3: rail_sense[k-1] = !bad;
			4: lower_window_sense = !bad;
			default: upper_window_sense = bad;
		endcase
	endtask
	// Fault pulse: immediate assertion, release only after the delay.
	task automatic flt_cycle(input int k, input int ch, input int d);
		set_flt(k, 1'b1);
		step(4);
		`CHK(rst_pin[ch], 1'b0)
		set_flt(k, 1'b0);
		step(d + 1);
		`CHK(rst_pin[ch], 1'b0)
		step(4);
		`CHK(rst_pin[ch], 1'b1)
	endtask
	task automatic t_power();
		`CHK(rst_pin, 4'h0)
		`CHK(wdo_pin, 1'b1)
		`CHK(channel_reset_oe, 4'hF)
		`CHK({pp_rst_oe, pp_rst_n}, 8'hF0)
		`CHK({watchdog_fault_oe, pp_wdo_oe, pp_wdo_n}, 3'h3)
		step(PRG + 8);
		`CHK(rst_pin, 4'h8)
		`CHK(channel_reset_oe, 4'h7)
		step(FIX);
		`CHK(rst_pin, 4'hF)
		`CHK({channel_reset_oe, pp_rst_oe, pp_rst_n}, 12'h0FF)
		$display("power-up done");
	endtask
	task automatic t_rails();
		flt_cycle(1, 0, FIX);
		flt_cycle(2, 1, FIX);
		flt_cycle(3, 2, FIX);
		flt_cycle(4, 3, PRG);
		flt_cycle(5, 3, PRG);
		flt_cycle(0, 0, FIX);
		$display("rails done");
	endtask
	// Programmed delays outside the legal span are pulled to its ends.
	task automatic t_clamp();
		delay_config = 4'h5;
		delay_prog_cycles[1] = 29'h2;
		flt_cycle(2, 1, MINC);
		delay_prog_cycles[1] = 29'h7D0;
		flt_cycle(2, 1, MAXC);
		delay_config = 4'h7;
		$display("clamp done");
	endtask
	task automatic t_mr_rail();
		set_flt(0, 1'b1);
		set_flt(1, 1'b1);
		step(4);
		set_flt(0, 1'b0);
		step(FIX + 8);
		`CHK(rst_pin[0], 1'b0)
		set_flt(1, 1'b0);
		step(FIX + 1);
		`CHK(rst_pin[0], 1'b0)
		step(4);
		`CHK(rst_pin[0], 1'b1)
		$display("manual reset done");
	endtask
	task automatic t_wdt();
		kick_en = 1'b0;
		step(WDT + 10);
		`CHK(wdo_pin, 1'b0)
		`CHK({watchdog_fault_oe, pp_wdo_oe, pp_wdo_n}, 3'h6)
		kick_en = 1'b1;
		step(30);
		`CHK(wdo_pin, 1'b0)
		set_flt(0, 1'b1);
		kick_en = 1'b0;
		step(WDT + 10);
		`CHK(wdo_pin, 1'b1)
		set_flt(0, 1'b0);
		kick_en = 1'b1;
		step(FIX + WDT + 30);
		`CHK(wdo_pin, 1'b1)
		$display("watchdog done");
	endtask
	task automatic results();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Main sequence.
	initial begin
		sys_rst = 1'b1;
		manual_reset_n = 1'b1;
		kick_en = 1'b1;
		rail_sense = 3'h7;
		lower_window_sense = 1'b1;
		upper_window_sense = 1'b0;
		delay_config = 4'h7;
		delay_prog_cycles = {4{29'h6}};
		step(12);
		sys_rst = 1'b0;
		t_power();
		t_rails();
		t_clamp();
		t_mr_rail();
		t_wdt();
		results();
	end
	// Cuts a hung run short.
	initial begin
		repeat (4000) @(posedge ref_clk);
		miscompares++;
		results();
	end
endmodule
bind quad_supervisor_reset_watchdog sup_monitor #(.FIXED_CYCLES(FIXED_CYCLES),
	.WDT_CYCLES(WDT_CYCLES)) sup_monitor_inst (.ref_clk, .sys_rst, .rail_sense,
	.upper_window_sense, .manual_reset_n, .watchdog_kick, .delay_config,
	.channel_reset_out_n, .watchdog_fault_n);
`default_nettype wire
